// File: src/eisc_top.sv
// external request sense front end with AXI4-Lite register slave
// assumes asynchronous pins, cpu state inputs on clk
`timescale 1ns/1ns
`include "eisc_defines.svh"
module eisc_top
  import eisc_pkg::*;
#(
  parameter int NLINES = 6,
  parameter int NPINS = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NLINES-1:0] external_request_lines,
  input wire logic [NPINS-1:0] port_interrupt_pins,
  input wire logic nm_pin,
  input wire eisc_cpu_t cpu_state,
  output logic [NLINES-1:0] request_line_flag,
  output logic port_group_low_flag,
  output logic port_group_high_flag,
  output logic [3:0] encoded_level_inputs,
  output logic all_masked,
  output logic nm_accept_en,
  output logic irq
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [NLINES-1:0] line_s1_ff, line_s2_ff;
  logic [NPINS-1:0] pin_s1_ff, pin_s2_ff;
  logic nm_s1_ff, nm_s2_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      line_s1_ff <= '1;
      line_s2_ff <= '1;
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      nm_s1_ff <= 1'b1;
      nm_s2_ff <= 1'b1;
    end else begin
      line_s1_ff <= external_request_lines;
      line_s2_ff <= line_s1_ff;
      pin_s1_ff <= port_interrupt_pins;
      pin_s2_ff <= pin_s1_ff;
      nm_s1_ff <= nm_pin;
      nm_s2_ff <= nm_s1_ff;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [15:0] irq_sense_control_ff;
  logic [15:0] port_irq_polarity_ff;
  logic [15:0] port_irq_enable_ff;
  logic [7:0] status_ff, mask_ff;
  logic [NLINES-1:0] line_clr_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic do_write;
  logic [15:0] nxt_lo;

  // both halves held while ready is low; write fires once bvalid is free
  assign do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] st);
    merge16 = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_addr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_ff <= s_axi_awaddr;
      end else if (do_write) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (do_write) begin
        s_axi_wready <= 1'b1;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_bresp = 2'h0;

  assign nxt_lo = merge16(irq_sense_control_ff, wdata_ff, wstrb_ff) & `EISC_SENSE_WMASK;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_sense_control_ff <= `EISC_RST_SENSE;
      port_irq_polarity_ff <= `EISC_RST_POL;
      port_irq_enable_ff <= `EISC_RST_PEN;
      mask_ff <= 8'h00;
    end else if (do_write) begin
      case (aw_addr_ff)
        `EISC_OFS_SENSE: irq_sense_control_ff <= nxt_lo;
        `EISC_OFS_POL: port_irq_polarity_ff <= merge16(port_irq_polarity_ff, wdata_ff,
                                                        wstrb_ff);
        `EISC_OFS_PEN: port_irq_enable_ff <= merge16(port_irq_enable_ff, wdata_ff,
                                                      wstrb_ff);
        `EISC_OFS_MASK: if (wstrb_ff[0]) mask_ff <= wdata_ff[7:0];
        default: ;
      endcase
    end
  end

  // write 0 to a flag bit clears an edge flag that was read as 1
  logic [NLINES-1:0] read_seen_ff;
  logic flags_rd;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      line_clr_ff <= '0;
      read_seen_ff <= '0;
    end else begin
      line_clr_ff <= '0;
      if (flags_rd) begin
        read_seen_ff <= read_seen_ff | request_line_flag;
      end
      if (do_write && aw_addr_ff == `EISC_OFS_FLAGS && wstrb_ff[0]) begin
        line_clr_ff <= read_seen_ff & ~wdata_ff[NLINES-1:0];
        read_seen_ff <= read_seen_ff & wdata_ff[NLINES-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // detection
  // ------------------------------------------------------------
  logic lmode;
  logic gmask_active;
  logic [NLINES-1:0] line_en;
  logic [NLINES-1:0] det_flag;
  logic [NPINS-1:0] pin_active;

  assign lmode = irq_sense_control_ff[`EISC_BIT_LMODE];
  assign gmask_active = irq_sense_control_ff[`EISC_BIT_GMASK] & ~nm_s2_ff;

  // lines 0-3 detected only when not encoded; 4,5 always
  genvar gi;
  generate
    for (gi = 0; gi < NLINES; gi++) begin : g_line
      assign line_en[gi] = (gi < 4) ? ~lmode : 1'b1;
      eisc_line_det u_det (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin(line_s2_ff[gi]),
        .en(line_en[gi]),
        .sense(eisc_sense_t'(irq_sense_control_ff[2*gi+1:2*gi])),
        .clr(line_clr_ff[gi]),
        .flag(det_flag[gi])
      );
    end
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      assign pin_active[gi] = port_irq_enable_ff[gi] &
        (pin_s2_ff[gi] ~^ port_irq_polarity_ff[gi]);
    end
  endgenerate

  logic grp_lo, grp_hi;
  assign grp_lo = |pin_active[7:0];
  assign grp_hi = |pin_active[15:8];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      request_line_flag <= '0;
      port_group_low_flag <= 1'b0;
      port_group_high_flag <= 1'b0;
      encoded_level_inputs <= 4'hF;
      all_masked <= 1'b0;
      nm_accept_en <= 1'b1;
    end else begin
      request_line_flag <= det_flag;
      port_group_low_flag <= grp_lo;
      port_group_high_flag <= grp_hi;
      // encoded level, active low, only in encoded mode
      encoded_level_inputs <= lmode ? line_s2_ff[3:0] : 4'hF;
      all_masked <= gmask_active;
      nm_accept_en <= ~(irq_sense_control_ff[`EISC_BIT_GMASK] & cpu_state.standby) &
        (~cpu_state.block_flag | irq_sense_control_ff[`EISC_BIT_OVR]);
    end
  end

  // ------------------------------------------------------------
  // sticky status, read to clear, masked interrupt
  // ------------------------------------------------------------
  logic [7:0] ev;
  logic [NLINES-1:0] prev_flag_ff;
  logic prev_lo_ff, prev_hi_ff;
  logic status_rd;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_flag_ff <= '0;
      prev_lo_ff <= 1'b0;
      prev_hi_ff <= 1'b0;
    end else begin
      prev_flag_ff <= request_line_flag;
      prev_lo_ff <= port_group_low_flag;
      prev_hi_ff <= port_group_high_flag;
    end
  end
  assign ev = {port_group_high_flag & ~prev_hi_ff, port_group_low_flag & ~prev_lo_ff,
               request_line_flag & ~prev_flag_ff};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_ff <= 8'h00;
    end else if (status_rd) begin
      status_ff <= ev;
    end else begin
      status_ff <= status_ff | ev;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_ff & mask_ff) & ~gmask_active;
    end
  end

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  logic [15:0] rd_val;
  assign status_rd = s_axi_arvalid & s_axi_arready & (s_axi_araddr == `EISC_OFS_STATUS);
  assign flags_rd = s_axi_arvalid & s_axi_arready & (s_axi_araddr == `EISC_OFS_FLAGS);
  always_comb begin
    case (s_axi_araddr)
      `EISC_OFS_SENSE: rd_val = irq_sense_control_ff & `EISC_SENSE_WMASK;
      `EISC_OFS_POL: rd_val = port_irq_polarity_ff;
      `EISC_OFS_PEN: rd_val = port_irq_enable_ff;
      `EISC_OFS_FLAGS: rd_val = {8'h00, port_group_low_flag, port_group_high_flag,
                                 request_line_flag};
      `EISC_OFS_STATUS: rd_val = {8'h00, status_ff};
      `EISC_OFS_MASK: rd_val = {8'h00, mask_ff};
      `EISC_OFS_MISC: rd_val = {13'h0000, nm_s2_ff, all_masked, nm_accept_en};
      default: rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_val};
      s_axi_arready <= 1'b0;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  assign s_axi_rresp = 2'h0;
endmodule : eisc_top

// File: src/eisc_defines.svh
// register offsets, field positions, reset values of the sense front end
// assumes inclusion by bare name from eisc_top
`ifndef EISC_DEFINES_SVH
`define EISC_DEFINES_SVH
`define EISC_OFS_SENSE 8'h00
`define EISC_OFS_POL 8'h04
`define EISC_OFS_PEN 8'h08
`define EISC_OFS_FLAGS 8'h0C
`define EISC_OFS_STATUS 8'h10
`define EISC_OFS_MASK 8'h14
`define EISC_OFS_MISC 8'h18
`define EISC_BIT_GMASK 15
`define EISC_BIT_LMODE 14
`define EISC_BIT_OVR 13
`define EISC_BIT_RSVD 12
`define EISC_RST_SENSE 16'h4000
`define EISC_RST_POL 16'h0000
`define EISC_RST_PEN 16'h0000
`define EISC_SENSE_WMASK 16'hEFFF
`endif

// File: src/eisc_pkg.sv
// types of the external request sense front end
// assumes eisc_defines.svh on the include path
package eisc_pkg;
  typedef enum logic [1:0] {
    EISC_FALL = 2'h0,
    EISC_RISE = 2'h1,
    EISC_LOW = 2'h2,
    EISC_HIGH = 2'h3
  } eisc_sense_t;
  typedef struct packed {
    logic nm_low;
    logic standby;
    logic block_flag;
  } eisc_cpu_t;
endpackage : eisc_pkg

// File: src/eisc_line_det.sv
// one request line detector with sticky edge flag
// assumes a synchronised pin level on the same clock
`timescale 1ns/1ns
module eisc_line_det
  import eisc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pin,
  input wire logic en,
  input wire eisc_sense_t sense,
  input wire logic clr,
  output logic flag
);
  logic prev_ff;
  logic edge_hit;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_ff <= 1'b1;
    end else begin
      prev_ff <= pin;
    end
  end
  always_comb begin
    case (sense)
      EISC_FALL: edge_hit = prev_ff & ~pin;
      EISC_RISE: edge_hit = ~prev_ff & pin;
      default: edge_hit = 1'b0;
    endcase
  end
  // set beats clear on edges; level follows pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag <= 1'b0;
    end else if (!en) begin
      flag <= 1'b0;
    end else if (sense == EISC_LOW) begin
      flag <= ~pin;
    end else if (sense == EISC_HIGH) begin
      flag <= pin;
    end else if (edge_hit) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end
endmodule : eisc_line_det

// File: tb/eisc_pin_model.sv
// far side pins: request lines, port pins, nm pin
// assumes the bench sets levels just after a clk edge
`timescale 1ns/1ns
module eisc_pin_model (
  input wire logic clk,
  input wire logic [21:0] pin_cmd,
  input wire logic nm_cmd,
  output logic [5:0] external_request_lines,
  output logic [15:0] port_interrupt_pins,
  output logic nm_pin
);
  always_ff @(posedge clk) begin
    {external_request_lines, port_interrupt_pins} <= pin_cmd;
    nm_pin <= nm_cmd;
  end
endmodule : eisc_pin_model

// File: tb/eisc_top_sva.sv
// concurrent checks on the sense front end ports
// assumes binding onto eisc_top, one clock domain
`timescale 1ns/1ns
module eisc_top_sva
  import eisc_pkg::*;
#(
  parameter int NLINES = 6
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NLINES-1:0] request_line_flag,
  input wire logic [3:0] encoded_level_inputs,
  input wire logic nm_pin,
  input wire eisc_cpu_t cpu_state,
  input wire logic all_masked,
  input wire logic nm_accept_en,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_mask_blocks_irq: assert property (all_masked [*2] |-> !irq)
    else $error("irq while all masked");
  a_nm_high_free: assert property (nm_pin [*5] |-> !all_masked)
    else $error("masked with nm pin high");
  a_nm_accept_free: assert property (
    (!cpu_state.standby && !cpu_state.block_flag) [*2] |-> nm_accept_en)
    else $error("nm refused without cause");
  a_encoded_excl: assert property (
    (encoded_level_inputs != 4'hF) [*3] |-> request_line_flag[3:0] == 4'h0)
    else $error("line flags while encoded");
  a_write_resp: assert property (s_axi_wvalid && s_axi_wready |->
    ##[1:3] (s_axi_bvalid && s_axi_bresp == 2'h0))
    else $error("no write response");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while busy");
endmodule : eisc_top_sva
bind eisc_top eisc_top_sva #(.NLINES(NLINES)) u_sva (.*);

// File: tb/eisc_top_tb.sv
// self-checking bench of the sense front end over AXI4-Lite
// assumes eisc_top, eisc_pin_model and the bound checker
`timescale 1ns/1ns
module eisc_top_tb;
  import eisc_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, nm_cmd = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, st, ex;
  logic [3:0] s_axi_wstrb = 4'h3, encoded_level_inputs;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] external_request_lines, request_line_flag, act;
  logic [15:0] port_interrupt_pins, pol, en, pv, hit;
  logic nm_pin, port_group_low_flag, port_group_high_flag, all_masked, nm_accept_en, irq;
  logic [21:0] pin_cmd = 22'h3F_0000;
  eisc_cpu_t cpu_state = 3'h0;
  logic [31:0] expq[$];
  int error_cnt = 0, num_checks = 0;
  always #25 clk = ~clk;
  eisc_pin_model pm (.*);
  eisc_top uut (.*);
  task automatic check(string w, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", w, e, g);
    end
  endtask : check
  task automatic wr(logic [7:0] a, logic [15:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin
        do @(negedge clk); while (s_axi_awready !== 1'b1);
        @(posedge clk);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(negedge clk); while (s_axi_wready !== 1'b1);
        @(posedge clk);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(negedge clk); while (s_axi_bvalid !== 1'b1);
    @(posedge clk);
    s_axi_bready <= 1'b1;
    do @(negedge clk); while (s_axi_bvalid !== 1'b1);
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e);
    expq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge clk); while (s_axi_arready !== 1'b1);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    @(posedge clk);
    s_axi_rready <= 1'b1;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic drv(logic [21:0] c);
    pin_cmd <= c;
    repeat (8) @(posedge clk);
  endtask : drv
  task automatic pchk(string w, logic [31:0] e);
    @(negedge clk);
    check(w, e, (w == "enc") ? {28'h0, encoded_level_inputs} : {31'h0, irq});
    @(posedge clk);
  endtask : pchk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      check("rdata", expq.pop_front(), s_axi_rdata);
      check("rresp", 32'h0, {30'h0, s_axi_rresp});
    end
  end
  initial begin
    #1000000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(65352));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(8'h00, 32'h4000);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h40, 32'h0);
    rd(8'h0C, 32'h0);
    wr(8'h00, 16'hFFFF);
    rd(8'h00, 32'hEFFF);
    $display("regs done");
    for (int m = 0; m < 4; m++) begin
      act = m[0] ? 6'h3F : 6'h0;
      wr(8'h00, {4'h0, {6{1'b1, m[0]}}});
      drv({~act, 16'h0});
      wr(8'h00, {4'h0, {6{m[1:0]}}});
      rd(8'h0C, 32'h0);
      drv({act, 16'h0});
      rd(8'h0C, 32'h3F);
      drv({~act, 16'h0});
      rd(8'h0C, m[1] ? 32'h0 : 32'h3F);
      wr(8'h0C, 16'h0);
      rd(8'h0C, 32'h0);
    end
    rd(8'h10, 32'h3F);
    $display("sense done");
    st = 32'h0;
    for (int i = 0; i < 6; i++) begin
      {pol, en} = $urandom;
      pv = 16'($urandom);
      wr(8'h08, 16'h0);
      wr(8'h04, pol);
      drv({6'h0, pv});
      wr(8'h08, en);
      hit = en & ~(pv ^ pol);
      ex = {24'h0, |hit[7:0], |hit[15:8], 6'h0};
      st = st | ex;
      rd(8'h0C, ex);
    end
    wr(8'h08, 16'h0);
    rd(8'h10, st);
    rd(8'h10, 32'h0);
    $display("port done");
    wr(8'h00, 16'h4FFF);
    drv({6'h35, 16'h0});
    pchk("enc", 32'h5);
    rd(8'h0C, 32'h30);
    wr(8'h00, 16'h0FFF);
    pchk("enc", 32'hF);
    rd(8'h0C, 32'h35);
    $display("mode done");
    pchk("irq", 32'h0);
    wr(8'h14, 16'h0001);
    pchk("irq", 32'h1);
    rd(8'h14, 32'h1);
    rd(8'h10, 32'h35);
    pchk("irq", 32'h0);
    drv({6'h34, 16'h0});
    drv({6'h35, 16'h0});
    pchk("irq", 32'h1);
    wr(8'h00, 16'h8FFF);
    nm_cmd <= 1'b0;
    repeat (8) @(posedge clk);
    pchk("irq", 32'h0);
    rd(8'h18, 32'h3);
    cpu_state.standby <= 1'b1;
    @(posedge clk);
    rd(8'h18, 32'h2);
    nm_cmd <= 1'b1;
    repeat (8) @(posedge clk);
    pchk("irq", 32'h1);
    rd(8'h18, 32'h4);
    cpu_state <= 3'h1;
    @(posedge clk);
    rd(8'h18, 32'h4);
    wr(8'h00, 16'h2FFF);
    rd(8'h18, 32'h5);
    $display("irq done");
    tally_and_finish();
  end
endmodule : eisc_top_tb
